// >>> safcr_pkg.sv
// constants for the setup and filter configuration register bank
// assumes a 32-bit apb slave with one register per aligned word
package safcr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SETUP_1  = 6'h21;
    localparam logic [5:0] IDX_SETUP_2  = 6'h22;
    localparam logic [5:0] IDX_SETUP_3  = 6'h23;
    localparam logic [5:0] IDX_FILTER_0 = 6'h28;

    localparam logic [15:0] SETUP_RESET  = 16'h1320;
    localparam logic [15:0] SETUP_WMASK  = 16'h1FB0;
    localparam logic [15:0] FILTER_RESET = 16'h0500;
    localparam logic [15:0] FILTER_WMASK = 16'h8F7F;

    // setup register field positions
    localparam int SETUP_POLARITY_BIT = 12;
    localparam int SETUP_REFBUF_P_BIT = 11;
    localparam int SETUP_REFBUF_N_BIT = 10;
    localparam int SETUP_INBUF_P_BIT  = 9;
    localparam int SETUP_INBUF_N_BIT  = 8;
    localparam int SETUP_BURNOUT_BIT  = 7;
    localparam int SETUP_REFSEL_LSB   = 4;

    // filter register field positions
    localparam int FILT_DIRECT_BIT  = 15;
    localparam int FILT_PF_EN_BIT   = 11;
    localparam int FILT_PF_SEL_LSB  = 8;
    localparam int FILT_ORDER_LSB   = 5;
    localparam int FILT_RATE_LSB    = 0;

    // field codes
    localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
    localparam logic [1:0] ORDER_SINC3       = 2'h3;
    localparam logic [2:0] PF_27_SPS         = 3'h2;
    localparam logic [2:0] PF_25_SPS         = 3'h3;
    localparam logic [2:0] PF_20_SPS         = 3'h5;
    localparam logic [2:0] PF_16_67_SPS      = 3'h6;
    localparam logic [4:0] RATE_250K         = 5'h00;
    localparam logic [4:0] RATE_5_SPS        = 5'h14;
    localparam logic [1:0] REF_EXTERNAL      = 2'h0;
    localparam logic [1:0] REF_INTERNAL      = 2'h2;
    localparam logic [1:0] REF_SUPPLY        = 2'h3;

    // direct decimation: modulator clock divided by 32 times the value
    localparam int DIRECT_PRE_DIV_LOG2 = 5;
    localparam int DIVISOR_W           = 20;

    // access selector codes
    localparam logic [2:0] SEL_NONE   = 3'h0;
    localparam logic [2:0] SEL_FILTER = 3'h4;

endpackage

// >>> safcr_setup_reg.sv
// one setup configuration register with its decoded field outputs
// assumes write strobe and data are already qualified by the bus slave
`timescale 1ns/100ps
`default_nettype none
module safcr_setup_reg
    import safcr_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_wr_en,
    input  wire logic [REG_W-1:0] i_wdata,
    output logic      [REG_W-1:0] o_value,
    output logic                  o_polarity_select,
    output logic                  o_ref_buffer_pos_en,
    output logic                  o_ref_buffer_neg_en,
    output logic                  o_input_buffer_pos_en,
    output logic                  o_input_buffer_neg_en,
    output logic                  o_open_wire_current_en,
    output logic      [1:0]       o_reference_source_select
);

    typedef struct packed
    {
        logic [REG_W-1:0] value;
    } safcr_setup_state_t;

    safcr_setup_state_t st_r;
    safcr_setup_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (i_wr_en)
        begin
            // reserved bits stay zero
            st_nxt.value = i_wdata & SETUP_WMASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_r.value <= SETUP_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_value                = st_r.value;
    assign o_polarity_select      = st_r.value[SETUP_POLARITY_BIT];
    assign o_ref_buffer_pos_en    = st_r.value[SETUP_REFBUF_P_BIT];
    assign o_ref_buffer_neg_en    = st_r.value[SETUP_REFBUF_N_BIT];
    assign o_input_buffer_pos_en  = st_r.value[SETUP_INBUF_P_BIT];
    assign o_input_buffer_neg_en  = st_r.value[SETUP_INBUF_N_BIT];
    assign o_open_wire_current_en = st_r.value[SETUP_BURNOUT_BIT];
    assign o_reference_source_select =
        st_r.value[SETUP_REFSEL_LSB +: 2];

endmodule // safcr_setup_reg
`default_nettype wire

// >>> safcr_regs.sv
// setup 1..3 and filter 0 configuration registers behind an apb slave
// assumes apb signals come from logic on I_CLK; zero wait state slave
`timescale 1ns/100ps
`default_nettype none

// Contract
// - setup registers 1 to 3 sit at indices 0x21 to 0x23, reset 0x1320.
// - setup bit 12 is polarity, 11/10 ref buffers, 9/8 input buffers.
// - setup bit 7 is burnout, 5:4 reference select, 6 and 3:0 reserved.
// - a filter write aborts conversion and restarts at the first channel.
// - filter bit 15 makes 14:0 the sinc3 decimation, divisor 32 times it.
// - filter bits 14:12 and 7 are read-only zero; software writes zero.
// - filter bit 11 enables the 50/60 Hz postfilter, only with order 00.
// - postfilter codes 010/011/101/110 give 27/25/20/16.67 SPS, reset 5.
// - order 00 selects sinc5 plus sinc1 (default), 11 selects sinc3.
// - rate code bits 4:0 set the output rate, 00000 being 250,000 SPS.
// - the first filter register sits at index 0x28 and resets to 0x0500.
// - ref select 00 external, 10 internal 2.5 V, 11 supply difference.
// - each input buffer enable bit turns its input buffer off or on.
// - the burnout bit drives matched open-wire test currents.
module safcr_regs
#(
    parameter int NUM_SETUPS = 3
)
(
    input  wire logic                           I_CLK,
    input  wire logic                           I_RESET_N,
    input  wire logic                           I_PSEL,
    input  wire logic                           I_PENABLE,
    input  wire logic                           I_PWRITE,
    input  wire logic [safcr_pkg::ADDR_W-1:0]   I_PADDR,
    input  wire logic [safcr_pkg::DATA_W-1:0]   I_PWDATA,
    output logic      [safcr_pkg::DATA_W-1:0]   O_PRDATA,
    output logic                                O_PREADY,
    output logic                                O_PSLVERR,
    output logic      [NUM_SETUPS-1:0]          O_POLARITY_SELECT,
    output logic      [NUM_SETUPS-1:0]          O_REF_BUFFER_POS_EN,
    output logic      [NUM_SETUPS-1:0]          O_REF_BUFFER_NEG_EN,
    output logic      [NUM_SETUPS-1:0]          O_INPUT_BUFFER_POS_EN,
    output logic      [NUM_SETUPS-1:0]          O_INPUT_BUFFER_NEG_EN,
    output logic      [NUM_SETUPS-1:0]          O_OPEN_WIRE_CURRENT_EN,
    output logic      [2*NUM_SETUPS-1:0]        O_REFERENCE_SOURCE_SELECT,
    output logic                                O_DIRECT_DECIMATION_MODE,
    output logic      [14:0]                    O_DECIMATION_RATE,
    output logic      [safcr_pkg::DIVISOR_W-1:0] O_MOD_DIVISOR,
    output logic      [1:0]                     O_FILTER_ORDER,
    output logic                                O_POSTFILTER_ACTIVE,
    output logic      [2:0]                     O_POSTFILTER_SELECT,
    output logic      [4:0]                     O_OUTPUT_RATE_CODE,
    output logic                                O_FILTER_CODE_RESERVED,
    output logic                                O_CONV_RESTART
);

    import safcr_pkg::*;

    if (NUM_SETUPS < 1 || NUM_SETUPS > 3)
    begin : g_bad_setups
        $error("NUM_SETUPS must lie between 1 and 3");
    end

    typedef struct packed
    {
        logic [REG_W-1:0]     filt;
        logic                 pready;
        logic [DATA_W-1:0]    prdata;
        logic                 pslverr;
        logic                 restart;
        logic                 direct;
        logic [14:0]          dec_rate;
        logic [DIVISOR_W-1:0] divisor;
        logic [1:0]           order;
        logic                 pf_active;
        logic [2:0]           pf_sel;
        logic [4:0]           rate;
        logic                 code_rsvd;
    } safcr_top_state_t;

    safcr_top_state_t st_r;
    safcr_top_state_t st_nxt;

    logic [REG_W-1:0]      setup_value [NUM_SETUPS];
    logic [NUM_SETUPS-1:0] setup_wr;
    logic [2:0]            acc_sel;
    logic                  setup_phase;
    logic                  commit;

    // decode a byte address into the register it selects
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        logic [5:0] rel;
        idx = addr[ADDR_W-1:2];
        rel = idx - IDX_SETUP_1;
        reg_sel = SEL_NONE;
        if (addr[1:0] != 2'h0)
        begin
            reg_sel = SEL_NONE;
        end
        else if (idx == IDX_FILTER_0)
        begin
            reg_sel = SEL_FILTER;
        end
        else if (idx >= IDX_SETUP_1 && idx <= IDX_SETUP_3 &&
                 int'(rel) < NUM_SETUPS)
        begin
            reg_sel = rel[2:0] + 3'h1;
        end
    endfunction

    // postfilter codes that have a defined response
    function automatic logic pf_code_ok(input logic [2:0] code);
        case (code)
            PF_27_SPS,
            PF_25_SPS,
            PF_20_SPS,
            PF_16_67_SPS:
                pf_code_ok = 1'b1;
            default:
                pf_code_ok = 1'b0;
        endcase
    endfunction

    // filter order codes that have a defined response
    function automatic logic order_code_ok(input logic [1:0] code);
        case (code)
            ORDER_SINC5_SINC1,
            ORDER_SINC3:
                order_code_ok = 1'b1;
            default:
                order_code_ok = 1'b0;
        endcase
    endfunction

    // read data for a decoded selector
    function automatic logic [DATA_W-1:0] read_word(
        input logic [2:0]       sel,
        input logic [REG_W-1:0] filt,
        input logic [REG_W-1:0] s1,
        input logic [REG_W-1:0] s2,
        input logic [REG_W-1:0] s3
    );
        logic [REG_W-1:0] v;
        v = '0;
        case (sel)
            3'h1:       v = s1;
            3'h2:       v = s2;
            3'h3:       v = s3;
            SEL_FILTER: v = filt;
            default:    v = '0;
        endcase
        read_word = {{(DATA_W-REG_W){1'b0}}, v};
    endfunction

    logic [REG_W-1:0] s_val [3];

    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            s_val[k] = (k < NUM_SETUPS) ? setup_value[k] : '0;
        end
    end

    assign acc_sel     = reg_sel(I_PADDR);
    assign setup_phase = I_PSEL & ~I_PENABLE;
    assign commit      = I_PSEL & I_PENABLE & st_r.pready;

    generate
        for (genvar g = 0; g < NUM_SETUPS; g++)
        begin : g_setup
            assign setup_wr[g] = commit & I_PWRITE &
                (acc_sel == 3'(g + 1));

            safcr_setup_reg u_setup
            (
                .i_clk                     (I_CLK),
                .i_reset_n                 (I_RESET_N),
                .i_wr_en                   (setup_wr[g]),
                .i_wdata                   (I_PWDATA[REG_W-1:0]),
                .o_value                   (setup_value[g]),
                .o_polarity_select         (O_POLARITY_SELECT[g]),
                .o_ref_buffer_pos_en       (O_REF_BUFFER_POS_EN[g]),
                .o_ref_buffer_neg_en       (O_REF_BUFFER_NEG_EN[g]),
                .o_input_buffer_pos_en     (O_INPUT_BUFFER_POS_EN[g]),
                .o_input_buffer_neg_en     (O_INPUT_BUFFER_NEG_EN[g]),
                .o_open_wire_current_en    (O_OPEN_WIRE_CURRENT_EN[g]),
                .o_reference_source_select (O_REFERENCE_SOURCE_SELECT[2*g+:2])
            );
        end
    endgenerate

    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.restart = 1'b0;

        // apb: ready during the first access cycle
        st_nxt.pready = setup_phase;
        if (setup_phase)
        begin
            st_nxt.pslverr = (acc_sel == SEL_NONE);
            st_nxt.prdata  = I_PWRITE ? '0 :
                read_word(acc_sel, st_r.filt,
                          s_val[0], s_val[1], s_val[2]);
        end
        else if (commit)
        begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = '0;
        end

        // filter register write; reserved bits forced to zero
        if (commit && I_PWRITE && acc_sel == SEL_FILTER)
        begin
            st_nxt.filt    = I_PWDATA[REG_W-1:0] & FILTER_WMASK;
            st_nxt.restart = 1'b1;
        end

        // decoded filter settings follow the stored register
        st_nxt.direct = st_nxt.filt[FILT_DIRECT_BIT];
        if (st_nxt.direct)
        begin
            st_nxt.dec_rate = st_nxt.filt[14:0];
            st_nxt.divisor  = DIVISOR_W'({st_nxt.filt[14:0],
                              DIRECT_PRE_DIV_LOG2'(0)});
            st_nxt.order     = ORDER_SINC3;
            st_nxt.pf_active = 1'b0;
            st_nxt.code_rsvd = (st_nxt.filt[14:0] == 15'h0000);
        end
        else
        begin
            st_nxt.dec_rate  = 15'h0000;
            st_nxt.divisor   = '0;
            st_nxt.order     = st_nxt.filt[FILT_ORDER_LSB +: 2];
            st_nxt.pf_active = st_nxt.filt[FILT_PF_EN_BIT] &&
                (st_nxt.order == ORDER_SINC5_SINC1) &&
                pf_code_ok(st_nxt.filt[FILT_PF_SEL_LSB +: 3]);
            st_nxt.code_rsvd =
                !order_code_ok(st_nxt.order) ||
                (st_nxt.filt[FILT_PF_EN_BIT] &&
                 !pf_code_ok(st_nxt.filt[FILT_PF_SEL_LSB +: 3])) ||
                (st_nxt.filt[FILT_RATE_LSB +: 5] > RATE_5_SPS);
        end
        st_nxt.pf_sel = st_nxt.filt[FILT_PF_SEL_LSB +: 3];
        st_nxt.rate   = st_nxt.filt[FILT_RATE_LSB +: 5];
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            st_r.filt      <= FILTER_RESET;
            st_r.pready    <= 1'b0;
            st_r.prdata    <= '0;
            st_r.pslverr   <= 1'b0;
            st_r.restart   <= 1'b0;
            st_r.direct    <= 1'b0;
            st_r.dec_rate  <= 15'h0000;
            st_r.divisor   <= '0;
            st_r.order     <= ORDER_SINC5_SINC1;
            st_r.pf_active <= 1'b0;
            st_r.pf_sel    <= FILTER_RESET[FILT_PF_SEL_LSB +: 3];
            st_r.rate      <= RATE_250K;
            st_r.code_rsvd <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign O_PRDATA                 = st_r.prdata;
    assign O_PREADY                 = st_r.pready;
    assign O_PSLVERR                = st_r.pslverr;
    assign O_DIRECT_DECIMATION_MODE = st_r.direct;
    assign O_DECIMATION_RATE        = st_r.dec_rate;
    assign O_MOD_DIVISOR            = st_r.divisor;
    assign O_FILTER_ORDER           = st_r.order;
    assign O_POSTFILTER_ACTIVE      = st_r.pf_active;
    assign O_POSTFILTER_SELECT      = st_r.pf_sel;
    assign O_OUTPUT_RATE_CODE       = st_r.rate;
    assign O_FILTER_CODE_RESERVED   = st_r.code_rsvd;
    assign O_CONV_RESTART           = st_r.restart;

endmodule // safcr_regs
`default_nettype wire

// >>> safcr_regs_sva.sv
// assertions for the setup and filter configuration register bank
// assumes binding to safcr_regs, single clock domain
`timescale 1ns/100ps
`default_nettype none
module safcr_sva
    import safcr_pkg::*;
#(
    parameter int NUM_SETUPS = 3
)
(
    input wire logic                            I_CLK,
    input wire logic                            I_RESET_N,
    input wire logic                            I_PSEL,
    input wire logic                            I_PENABLE,
    input wire logic                            I_PWRITE,
    input wire logic [safcr_pkg::ADDR_W-1:0]    I_PADDR,
    input wire logic [safcr_pkg::DATA_W-1:0]    I_PWDATA,
    input wire logic [safcr_pkg::DATA_W-1:0]    O_PRDATA,
    input wire logic                            O_PREADY,
    input wire logic                            O_PSLVERR,
    input wire logic [NUM_SETUPS-1:0]           O_POLARITY_SELECT,
    input wire logic [NUM_SETUPS-1:0]           O_OPEN_WIRE_CURRENT_EN,
    input wire logic [2*NUM_SETUPS-1:0]         O_REFERENCE_SOURCE_SELECT,
    input wire logic                            O_DIRECT_DECIMATION_MODE,
    input wire logic [14:0]                     O_DECIMATION_RATE,
    input wire logic [safcr_pkg::DIVISOR_W-1:0] O_MOD_DIVISOR,
    input wire logic [1:0]                      O_FILTER_ORDER,
    input wire logic                            O_POSTFILTER_ACTIVE,
    input wire logic [2:0]                      O_POSTFILTER_SELECT,
    input wire logic                            O_CONV_RESTART
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence setup_s(a);
        I_PSEL && !I_PENABLE && I_PADDR == a;
    endsequence
    sequence commit_s(a);
        I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == a;
    endsequence
    unmapped_error_a: assert property (
        setup_s(8'h80) |=> O_PREADY && O_PSLVERR && O_PRDATA == 32'h0)
        else $error("unmapped access not refused");
    polarity_write_a: assert property (
        commit_s(8'h84) |=> O_POLARITY_SELECT[0] == $past(I_PWDATA[12]))
        else $error("polarity field not taken");
    burnout_refsel_a: assert property (
        commit_s(8'h88) |=> O_OPEN_WIRE_CURRENT_EN[1] == $past(I_PWDATA[7])
        && O_REFERENCE_SOURCE_SELECT[3:2] == $past(I_PWDATA[5:4]))
        else $error("burnout or reference field not taken");
    setup_reserved_a: assert property (
        I_PENABLE && O_PREADY && !I_PWRITE && I_PADDR == 8'h8C
        |-> O_PRDATA[6] == 1'b0 && O_PRDATA[3:0] == 4'h0)
        else $error("setup reserved bits not zero");
    restart_pulse_a: assert property (
        commit_s(8'hA0) |=> O_CONV_RESTART ##1 !O_CONV_RESTART)
        else $error("restart pulse missing after filter write");
    restart_cause_a: assert property (
        O_CONV_RESTART |-> $past(I_PADDR) == 8'hA0 && $past(I_PWRITE)
        && $past(I_PENABLE))
        else $error("restart without filter write");
    direct_map_a: assert property (
        O_DIRECT_DECIMATION_MODE
        |-> O_MOD_DIVISOR == {O_DECIMATION_RATE, 5'h00}
        && O_FILTER_ORDER == ORDER_SINC3 && !O_POSTFILTER_ACTIVE)
        else $error("direct decimation mapping wrong");
    filter_reserved_a: assert property (
        O_PREADY && !I_PWRITE && I_PADDR == 8'hA0
        |-> O_PRDATA[14:12] == 3'h0 && !O_PRDATA[7])
        else $error("filter reserved bits not zero");
    postfilter_gate_a: assert property (
        O_POSTFILTER_ACTIVE |-> O_FILTER_ORDER == 2'h0
        && O_POSTFILTER_SELECT inside {3'h2, 3'h3, 3'h5, 3'h6})
        else $error("postfilter active in wrong mode");
endmodule // safcr_sva
`default_nettype wire

// >>> test_safcr_regs.sv
// self-checking bench for the setup and filter register bank
// assumes the bank is reached over apb, one 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_safcr_regs;
    import safcr_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, dmode, pf_act, reserved, restart;
    logic [2:0]  pol, rbp, rbn, ibp, ibn, bo, pf_sel;
    logic [5:0]  refsel;
    logic [14:0] dec;
    logic [19:0] div;
    logic [1:0]  order;
    logic [4:0]  rate;
    int          miscompares, n_tests;
    safcr_regs #(.NUM_SETUPS(3)) DUT (.I_CLK(clk), .I_RESET_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_POLARITY_SELECT(pol),
        .O_REF_BUFFER_POS_EN(rbp), .O_REF_BUFFER_NEG_EN(rbn),
        .O_INPUT_BUFFER_POS_EN(ibp), .O_INPUT_BUFFER_NEG_EN(ibn),
        .O_OPEN_WIRE_CURRENT_EN(bo), .O_REFERENCE_SOURCE_SELECT(refsel),
        .O_DIRECT_DECIMATION_MODE(dmode), .O_DECIMATION_RATE(dec),
        .O_MOD_DIVISOR(div), .O_FILTER_ORDER(order),
        .O_POSTFILTER_ACTIVE(pf_act), .O_POSTFILTER_SELECT(pf_sel),
        .O_OUTPUT_RATE_CODE(rate), .O_FILTER_CODE_RESERVED(reserved),
        .O_CONV_RESTART(restart));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic wrap_up;
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge clk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            miscompares++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
        input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 16'h0000, rd, er);
        `CHK(rd, e)
        `CHK(er, ee)
    endtask
    task automatic t_reset;
        for (int k = 0; k < 3; k++)
            rd_chk(8'h84 + 8'(4 * k), 32'h1320, 1'b0);
        rd_chk(8'hA0, 32'h0500, 1'b0);
        `CHK(pol & ibp & ibn, 3'h7)
        `CHK(rbp | rbn | bo, 3'h0)
        `CHK(refsel, 6'h2A)
        `CHK(pf_sel, PF_20_SPS)
        `CHK(({order, rate, dmode, pf_act}), 9'h000)
    endtask
    task automatic t_setup;
        logic [7:0] a;
        logic [5:0] f;
        for (int k = 0; k < 3; k++)
        begin
            a = 8'h84 + 8'(4 * k);
            wr(a, 16'hFFFF);
            f = {pol[k], rbp[k], rbn[k], ibp[k], ibn[k], bo[k]};
            `CHK(f, 6'h3F)
            `CHK(refsel[2*k +: 2], REF_SUPPLY)
            rd_chk(a, 32'h1FB0, 1'b0);
            wr(a, 16'h0020);
            f = {pol[k], rbp[k], rbn[k], ibp[k], ibn[k], bo[k]};
            `CHK(f, 6'h00)
            `CHK(refsel[2*k +: 2], REF_INTERNAL)
        end
        wr(8'h84, 16'h0000);
        `CHK(refsel, ({REF_INTERNAL, REF_INTERNAL, REF_EXTERNAL}))
    endtask
    task automatic t_direct;
        wr(8'hA0, 16'hFFFF);
        `CHK(restart, 1'b1)
        `CHK(({dmode, order, pf_act}), 4'hE)
        `CHK(dec, 15'h0F7F)
        `CHK(div, 20'h1EFE0)
        @(negedge clk);
        `CHK(restart, 1'b0)
        rd_chk(8'hA0, 32'h00008F7F, 1'b0);
    endtask
    task automatic t_filter;
        logic [2:0] pf[4];
        logic [4:0] rc[6];
        pf = '{PF_27_SPS, PF_25_SPS, PF_20_SPS, PF_16_67_SPS};
        rc = '{RATE_250K, 5'h01, 5'h02, 5'h03, RATE_5_SPS, 5'h15};
        foreach (pf[i])
        begin
            wr(8'hA0, {4'h0, 1'b1, pf[i], 8'h00});
            `CHK(({pf_act, pf_sel}), ({1'b1, pf[i]}))
            `CHK(({dmode, dec, div}), 36'h0)
        end
        wr(8'hA0, 16'h0D60);
        `CHK(({pf_act, order}), 3'h3)
        wr(8'hA0, 16'h0D20);
        `CHK(reserved, 1'b1)
        wr(8'hA0, 16'h0C00);
        `CHK(reserved, 1'b1)
        foreach (rc[i])
        begin
            wr(8'hA0, {11'h000, rc[i]});
            `CHK(rate, rc[i])
            `CHK(reserved, rc[i] > RATE_5_SPS)
        end
    endtask
    task automatic t_unmapped;
        logic [7:0]  ad[4];
        logic [31:0] rd;
        logic        er;
        ad = '{8'h80, 8'h85, 8'h90, 8'hA4};
        foreach (ad[i])
        begin
            apb(1'b1, ad[i], 16'hFFFF, rd, er);
            `CHK(er, 1'b1)
            rd_chk(ad[i], 32'h0, 1'b1);
        end
        rd_chk(8'h84, 32'h0, 1'b0);
    endtask
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        miscompares = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_setup();
        t_direct();
        t_filter();
        t_unmapped();
        wrap_up();
    end
endmodule // test_safcr_regs
bind safcr_regs safcr_sva #(.NUM_SETUPS(NUM_SETUPS)) u_sva (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_POLARITY_SELECT(O_POLARITY_SELECT),
    .O_OPEN_WIRE_CURRENT_EN(O_OPEN_WIRE_CURRENT_EN),
    .O_REFERENCE_SOURCE_SELECT(O_REFERENCE_SOURCE_SELECT),
    .O_DIRECT_DECIMATION_MODE(O_DIRECT_DECIMATION_MODE),
    .O_DECIMATION_RATE(O_DECIMATION_RATE), .O_MOD_DIVISOR(O_MOD_DIVISOR),
    .O_FILTER_ORDER(O_FILTER_ORDER), .O_POSTFILTER_ACTIVE(O_POSTFILTER_ACTIVE),
    .O_POSTFILTER_SELECT(O_POSTFILTER_SELECT),
    .O_CONV_RESTART(O_CONV_RESTART));
`default_nettype wire
